// ### core/sad_pkg.sv
package sad_pkg;

   // Destinations
   typedef enum logic [2:0] {
      SAD_DEST_MEM,
      SAD_DEST_PORT_A,
      SAD_DEST_PORT_B,
      SAD_DEST_PORT_C,
      SAD_DEST_PORT_D,
      SAD_DEST_SYSBUS
   } sad_dest_t;

   // Requesting source
   typedef enum logic [2:0] {
      SAD_SRC_CPU,
      SAD_SRC_HUB_A,
      SAD_SRC_HUB_B,
      SAD_SRC_HUB_C,
      SAD_SRC_HUB_D
   } sad_src_t;

   typedef struct packed {
      logic        valid;
      sad_src_t    src;
      logic        is_io;
      logic        is_write;
      logic        smm_code;
      logic        dword;
      logic [33:0] addr;
   } sad_req_t;

   typedef struct packed {
      logic        valid;
      sad_dest_t   dest;
      logic        int_msg;
      logic        self_target_ready_signal;
      logic [33:0] addr;
   } sad_route_t;

   // Address map boundaries
   localparam logic [33:0] SAD_ONE_MB      = 34'h0_0010_0000;
   localparam logic [33:0] SAD_FOUR_GB     = 34'h1_0000_0000;
   localparam logic [33:0] SAD_VGA_LO      = 34'h0_000A_0000;
   localparam logic [33:0] SAD_VGA_HI      = 34'h0_000B_FFFF;
   localparam logic [33:0] SAD_MONO_LO     = 34'h0_000B_0000;
   localparam logic [33:0] SAD_MONO_HI     = 34'h0_000B_7FFF;
   localparam logic [33:0] SAD_ISA_EXP_LO  = 34'h0_000C_0000;
   localparam logic [33:0] SAD_EXT_BIOS_LO = 34'h0_000E_0000;
   localparam logic [33:0] SAD_SYS_BIOS_LO = 34'h0_000F_0000;
   localparam logic [33:0] SAD_HOLE_LO     = 34'h0_00F0_0000;
   localparam logic [33:0] SAD_HOLE_HI     = 34'h0_00FF_FFFF;
   localparam logic [33:0] SAD_IOAPIC_LO   = 34'h0_FEC0_0000;
   localparam logic [33:0] SAD_IOAPIC0_HI  = 34'h0_FEC7_FFFF;
   localparam logic [33:0] SAD_IOAPIC3_HI  = 34'h0_FEC8_2FFF;
   localparam logic [33:0] SAD_INTMSG_LO   = 34'h0_FEE0_0000;
   localparam logic [33:0] SAD_INTMSG_HI   = 34'h0_FEEF_FFFF;
   localparam logic [33:0] SAD_IO_LIMIT    = 34'h0_0001_0002;
   localparam int          SAD_SEG_SHIFT   = 14;
   localparam int          SAD_IOAPIC_SHIFT = 12;

   // Monochrome adapter I/O ports
   localparam logic [15:0] SAD_MONO_IO_0 = 16'h03B4;
   localparam logic [15:0] SAD_MONO_IO_1 = 16'h03B5;
   localparam logic [15:0] SAD_MONO_IO_2 = 16'h03B8;
   localparam logic [15:0] SAD_MONO_IO_3 = 16'h03B9;
   localparam logic [15:0] SAD_MONO_IO_4 = 16'h03BA;
   localparam logic [15:0] SAD_MONO_IO_5 = 16'h03BF;

   // Shadow attribute encoding {write_en, read_en}
   localparam logic [1:0] SAD_ATTR_RD = 2'h1;
   localparam logic [1:0] SAD_ATTR_WR = 2'h2;
   localparam int         SAD_NUM_SEG = 13;
   localparam logic [2*SAD_NUM_SEG-1:0] SAD_ATTR_RESET = 26'h0;

   // Identification register
   localparam logic [7:0]  SAD_IDENT_OFFSET = 8'h02;
   localparam logic [15:0] SAD_IDENT_C_F0   = 16'hA001; // Arbitrary
   localparam logic [15:0] SAD_IDENT_C_F1   = 16'hA002; // Arbitrary
   localparam logic [15:0] SAD_IDENT_D_F0   = 16'hA003; // Arbitrary
   localparam logic [15:0] SAD_IDENT_D_F1   = 16'hA004; // Arbitrary

endpackage

// ### core/sad_decoder.sv
// Overview of operation
// - Accept 34-bit host memory addresses and I/O up to 64 KB plus three.
// - Low-memory-top to 4 GB holds interrupt-controller and port windows only.
// - Below 1 MB and 1 MB to low-memory-top go to system memory.
// - Video and monochrome windows go to primary port, else enabled bridge.
// - Monochrome-present bit sends monochrome window to primary port.
// - Monochrome adapter I/O ports are forwarded to the primary port.
// - SMM enabled and open or processor code request steers video to memory.
// - ISA expansion: eight 16 KB segments, each read/write attribute.
// - Extended BIOS: four 16 KB segments with read and write attributes.
// - System BIOS: one 64 KB segment, disabled after reset.
// - Hub-port accesses hitting shadow regions always go to memory.
// - ISA hole enable relays 15 to 16 MB to primary port.
// - Interrupt-controller windows route processor accesses to A, B, C, D.
// - Hub-port dword writes to interrupt space go to system bus.
// - Device terminates hub-port interrupt message with response and target ready.
// - Processor writes to interrupt space are carried on system bus.
// - Port C and D bridge identification values are read-only.
// - Unclaimed low-memory-top to 4 GB goes subtractively to primary.
`timescale 1ns/1ps
`default_nettype none

module sad_decoder #(
   parameter logic [15:0] IDENT_C_F0 = sad_pkg::SAD_IDENT_C_F0, // arbitrary
   parameter logic [15:0] IDENT_C_F1 = sad_pkg::SAD_IDENT_C_F1, // arbitrary
   parameter logic [15:0] IDENT_D_F0 = sad_pkg::SAD_IDENT_D_F0, // arbitrary
   parameter logic [15:0] IDENT_D_F1 = sad_pkg::SAD_IDENT_D_F1  // arbitrary
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // Request in, route out
   input  wire sad_pkg::sad_req_t req,
   output var sad_pkg::sad_route_t route,
   // Configuration
   input  wire logic [33:0]       low_memory_top,
   input  wire logic [2:0]        video_route_en,
   input  wire logic              monochrome_present_bit,
   input  wire logic              smm_global_enable,
   input  wire logic              smm_open,
   input  wire logic              isa_hole_enable,
   input  wire logic              attr_wr,
   input  wire logic [25:0]       attr_wdata,
   output logic [25:0]            shadow_attribute_region,
   // Identification register reads
   input  wire logic              ident_rd,
   input  wire logic [1:0]        ident_func,
   input  wire logic [7:0]        ident_offset,
   output logic [15:0]            ident_rdata
);

   ////////////////////////////////////////////////////////////////////////
   // Shadow attributes: two bits per segment, segment 12 is system BIOS

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         shadow_attribute_region <= sad_pkg::SAD_ATTR_RESET;
      end else if (attr_wr) begin
         shadow_attribute_region <= attr_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Region decode

   wire logic [33:0] a       = req.addr;
   wire logic        is_cpu  = (req.src == sad_pkg::SAD_SRC_CPU);
   wire logic        in_vga  = a >= sad_pkg::SAD_VGA_LO &&
                               a <= sad_pkg::SAD_VGA_HI;
   wire logic        in_mono = a >= sad_pkg::SAD_MONO_LO &&
                               a <= sad_pkg::SAD_MONO_HI;
   wire logic        in_shadow = a >= sad_pkg::SAD_ISA_EXP_LO &&
                                 a < sad_pkg::SAD_ONE_MB;
   wire logic        in_hole = a >= sad_pkg::SAD_HOLE_LO &&
                               a <= sad_pkg::SAD_HOLE_HI;
   wire logic        in_low  = a < low_memory_top;
   wire logic        in_high = a >= sad_pkg::SAD_FOUR_GB;
   wire logic        in_apic = a >= sad_pkg::SAD_IOAPIC_LO &&
                               a <= sad_pkg::SAD_IOAPIC3_HI;
   wire logic        in_apic0 = a <= sad_pkg::SAD_IOAPIC0_HI;
   wire logic        in_int  = a >= sad_pkg::SAD_INTMSG_LO &&
                               a <= sad_pkg::SAD_INTMSG_HI;
   wire logic        io_ok   = a <= sad_pkg::SAD_IO_LIMIT;

   // Segment index: 0..7 ISA expansion, 8..11 extended BIOS, 12 system BIOS
   wire logic [3:0] seg_idx = (a >= sad_pkg::SAD_SYS_BIOS_LO) ? 4'hC :
      4'(a[19:sad_pkg::SAD_SEG_SHIFT] - 6'h30);
   wire logic [1:0] seg_attr = shadow_attribute_region[2*seg_idx +: 2];
   wire logic       seg_hit  = req.is_write ?
      |(seg_attr & sad_pkg::SAD_ATTR_WR) :
      |(seg_attr & sad_pkg::SAD_ATTR_RD);

   // SMM reclaim of the video window
   wire logic smm_video = smm_global_enable &&
                          (smm_open || (is_cpu && req.smm_code));

   // 4 KB interrupt-controller window index above the primary window
   wire logic [1:0] apic_sel =
      a[sad_pkg::SAD_IOAPIC_SHIFT+1:sad_pkg::SAD_IOAPIC_SHIFT];

   function automatic sad_pkg::sad_dest_t bridge_dest(input logic [1:0] n);
      case (n)
         2'h0:    bridge_dest = sad_pkg::SAD_DEST_PORT_B;
         2'h1:    bridge_dest = sad_pkg::SAD_DEST_PORT_C;
         2'h2:    bridge_dest = sad_pkg::SAD_DEST_PORT_D;
         default: bridge_dest = sad_pkg::SAD_DEST_PORT_A;
      endcase
   endfunction

   // Bridge chosen for video; lowest set enable wins if misprogrammed
   wire sad_pkg::sad_dest_t video_dest =
      video_route_en[0] ? bridge_dest(2'h0) :
      video_route_en[1] ? bridge_dest(2'h1) :
      video_route_en[2] ? bridge_dest(2'h2) :
                          sad_pkg::SAD_DEST_PORT_A;

   ////////////////////////////////////////////////////////////////////////
   // Destination selection

   sad_pkg::sad_dest_t next_dest;
   logic               next_int;

   always_comb begin
      next_int  = 1'b0;
      next_dest = sad_pkg::SAD_DEST_PORT_A;
      if (req.is_io) begin
         // Non-monochrome I/O also lands on the primary port here
         next_dest = sad_pkg::SAD_DEST_PORT_A;
      end else if (in_int && req.is_write &&
                   (is_cpu || req.dword)) begin
         next_dest = sad_pkg::SAD_DEST_SYSBUS;
         next_int  = 1'b1;
      end else if (in_high) begin
         next_dest = sad_pkg::SAD_DEST_MEM;
      end else if (in_vga) begin
         if (smm_video) begin
            next_dest = sad_pkg::SAD_DEST_MEM;
         end else if (in_mono && monochrome_present_bit) begin
            next_dest = sad_pkg::SAD_DEST_PORT_A;
         end else begin
            next_dest = video_dest;
         end
      end else if (in_shadow) begin
         if (!is_cpu || seg_hit) begin
            next_dest = sad_pkg::SAD_DEST_MEM;
         end else begin
            next_dest = sad_pkg::SAD_DEST_PORT_A;
         end
      end else if (in_hole && isa_hole_enable) begin
         next_dest = sad_pkg::SAD_DEST_PORT_A;
      end else if (in_low) begin
         next_dest = sad_pkg::SAD_DEST_MEM;
      end else if (in_apic && is_cpu) begin
         if (in_apic0) begin
            next_dest = sad_pkg::SAD_DEST_PORT_A;
         end else begin
            next_dest = bridge_dest(apic_sel);
         end
      end else begin
         next_dest = sad_pkg::SAD_DEST_PORT_A;
      end
   end

   wire logic next_valid = req.valid && (!req.is_io || io_ok);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         route <= '0;
      end else begin
         route.valid     <= next_valid;
         route.dest      <= next_dest;
         route.int_msg   <= next_valid && next_int;
         route.self_target_ready_signal <= next_valid && next_int && !is_cpu;
         route.addr      <= a;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Identification registers; writes are not accepted at all

   wire logic [15:0] ident_sel =
      (ident_func == 2'h0) ? IDENT_C_F0 :
      (ident_func == 2'h1) ? IDENT_C_F1 :
      (ident_func == 2'h2) ? IDENT_D_F0 : IDENT_D_F1;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ident_rdata <= 16'h0000;
      end else if (ident_rd) begin
         ident_rdata <= (ident_offset == sad_pkg::SAD_IDENT_OFFSET) ?
                        ident_sel : 16'h0000;
      end
   end

endmodule

`default_nettype wire

// ### verif/sad_decoder_props.sv
`timescale 1ns/1ps
`default_nettype none
module sad_decoder_props (
   // Clock and reset
   input wire logic                clk,
   input wire logic                rst_b,
   // Route path
   input wire sad_pkg::sad_req_t   req,
   input wire sad_pkg::sad_route_t route,
   // Configuration and identification
   input wire logic                smm_global_enable,
   input wire logic                smm_open,
   input wire logic                ident_rd,
   input wire logic [7:0]          ident_offset,
   input wire logic [15:0]         ident_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic [33:0] a = req.addr;
   wire logic m = req.valid && !req.is_io;
   wire logic hub = req.src != sad_pkg::SAD_SRC_CPU;
   wire logic imsg = m && req.is_write && a[33:20] == 14'h0FEE;
   wire logic to_mem = route.valid && route.dest == sad_pkg::SAD_DEST_MEM;
   wire logic to_a = route.valid && route.dest == sad_pkg::SAD_DEST_PORT_A;
   wire logic to_sys = route.valid && route.dest == sad_pkg::SAD_DEST_SYSBUS;
   property p_io; req.valid && req.is_io && a <= 34'h0_0001_0002 |=> to_a;
   endproperty
   a_io: assert property (p_io) else $error("io not to port a");
   property p_low; m && a < 34'h0_000A_0000 |=> to_mem; endproperty
   a_low: assert property (p_low) else $error("low not memory");
   property p_smm; m && a[33:17] == 17'h00005 && smm_global_enable &&
      (smm_open || !hub && req.smm_code) |=> to_mem; endproperty
   a_smm: assert property (p_smm) else $error("smm video wrong");
   property p_shd; m && hub && a[33:18] == 16'h0003 |=> to_mem; endproperty
   a_shd: assert property (p_shd) else $error("hub shadow wrong");
   property p_msg; imsg && hub && req.dword
      |=> to_sys && route.int_msg && route.self_target_ready_signal; endproperty
   a_msg: assert property (p_msg) else $error("msg wrong");
   property p_ipi; imsg && !hub |=> to_sys && !route.self_target_ready_signal; endproperty
   a_ipi: assert property (p_ipi) else $error("ipi wrong");
   property p_idz; ident_rd && ident_offset != 8'h02
      |=> ident_rdata == 16'h0000; endproperty
   a_idz: assert property (p_idz) else $error("ident nonzero");
   // Reset in the sampled cycle legitimately clears the read value
   property p_idh; rst_b && !ident_rd |=> $stable(ident_rdata); endproperty
   a_idh: assert property (p_idh) else $error("ident moved");
   cover property (route.int_msg && route.self_target_ready_signal);
   cover property (route.dest == sad_pkg::SAD_DEST_PORT_D);
   cover property (ident_rd && ident_offset == 8'h02);
endmodule
////////////////////////////////////////////////////////////
bind sad_decoder sad_decoder_props sad_decoder_props_i (.clk, .rst_b, .req,
   .route, .smm_global_enable, .smm_open, .ident_rd, .ident_offset,
   .ident_rdata);
`default_nettype wire

// ### verif/sad_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sad_host_model (
   // Clock
   input wire logic              clk,
   // Request toward the decoder
   output var sad_pkg::sad_req_t req
);
   initial req = '0;
   // Flags are {io, write, smm code, dword}; held until the next send
   task automatic send(sad_pkg::sad_src_t s, logic [3:0] f, logic [33:0] a);
      @(posedge clk);
      req <= '{1'b1, s, f[3], f[2], f[1], f[0], a};
   endtask
endmodule
`default_nettype wire

// ### verif/tb_sad_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sad_decoder;
   localparam sad_pkg::sad_src_t C = sad_pkg::SAD_SRC_CPU;
   localparam sad_pkg::sad_src_t H = sad_pkg::SAD_SRC_HUB_A;
   localparam sad_pkg::sad_dest_t MEM = sad_pkg::SAD_DEST_MEM;
   localparam sad_pkg::sad_dest_t A = sad_pkg::SAD_DEST_PORT_A;
   localparam sad_pkg::sad_dest_t SYS = sad_pkg::SAD_DEST_SYSBUS;
   logic clk = 0, rst_b = 0, monochrome_present_bit = 0, attr_wr = 0;
   logic smm_global_enable = 0, smm_open = 0, isa_hole_enable = 0;
   logic        ident_rd = 0;
   logic [33:0] low_memory_top = 34'h0_8000_0000;
   logic [2:0]  video_route_en = 3'h0;
   // Segments that hub ports touch are read/write
   logic [25:0] attr_wdata = 26'h103_0309, shadow_attribute_region;
   logic [1:0]  ident_func = 2'h0;
   logic [7:0]  ident_offset = 8'h00;
   logic [15:0] ident_rdata;
   logic [15:0] io_ports [6] = '{sad_pkg::SAD_MONO_IO_0,
      sad_pkg::SAD_MONO_IO_1, sad_pkg::SAD_MONO_IO_2, sad_pkg::SAD_MONO_IO_3,
      sad_pkg::SAD_MONO_IO_4, sad_pkg::SAD_MONO_IO_5};
   logic [15:0] ids [4] = '{sad_pkg::SAD_IDENT_C_F0, sad_pkg::SAD_IDENT_C_F1,
                           sad_pkg::SAD_IDENT_D_F0, sad_pkg::SAD_IDENT_D_F1};
   sad_pkg::sad_req_t   req;
   sad_pkg::sad_route_t route;
   int miscompares = 0, checked = 0;
   sad_host_model sad_host_model_i (.clk, .req);
   sad_decoder sad_decoder_i (.clk, .rst_b, .req, .route, .low_memory_top,
      .video_route_en, .monochrome_present_bit, .smm_global_enable,
      .smm_open, .isa_hole_enable, .attr_wr, .attr_wdata,
      .shadow_attribute_region, .ident_rd, .ident_func, .ident_offset,
      .ident_rdata);
   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////
   task automatic cmp(string n, logic [39:0] s, logic [39:0] e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rt(sad_pkg::sad_src_t s, logic [3:0] f, logic [33:0] a,
                     sad_pkg::sad_dest_t d, logic [1:0] mt = 2'h0);
      sad_host_model_i.send(s, f, a);
      @(posedge clk);
      #1 cmp("route", {route.valid, route.dest, route.int_msg,
                       route.self_target_ready_signal, route.addr}, {1'b1, d, mt, a});
   endtask
   task automatic idr(logic [1:0] fn, logic [7:0] o, logic [15:0] e);
      @(posedge clk) ident_rd <= 1;
      ident_func <= fn;
      ident_offset <= o;
      @(posedge clk) ident_rd <= 0;
      #1 cmp("ident", ident_rdata, e);
   endtask
   task automatic summarize();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      sad_pkg::sad_dest_t v;
      repeat (10) @(posedge clk);
      rst_b <= 1;
      #1 cmp("attr_reset", shadow_attribute_region, 26'h0);
      rt(C, 4'h0, 34'h0_0000_0000, MEM);
      rt(C, 4'h4, 34'h0_7FFF_FFFF, MEM);
      rt(C, 4'h0, 34'h0_8000_0000, A);
      rt(C, 4'h0, 34'h3_FFFF_FFFF, MEM);
      rt(C, 4'h0, 34'h0_000B_8000, A);
      for (int i = 0; i < 3; i++) begin
         v = sad_pkg::sad_dest_t'(2 + i);
         @(posedge clk) video_route_en <= 3'h1 << i;
         rt(C, 4'h0, 34'h0_000A_0000, v);
         rt(C, 4'h0, 34'h0_000B_0000, v);
         @(posedge clk) monochrome_present_bit <= 1;
         rt(C, 4'h4, 34'h0_000B_7FFF, A);
         rt(C, 4'h0, 34'h0_000B_8000, v);
         @(posedge clk) monochrome_present_bit <= 0;
      end
      @(posedge clk) smm_global_enable <= 1;
      rt(C, 4'h0, 34'h0_000A_0000, v);
      rt(C, 4'h2, 34'h0_000A_0000, MEM);
      @(posedge clk) smm_open <= 1;
      rt(H, 4'h0, 34'h0_000B_0000, MEM);
      @(posedge clk) smm_global_enable <= 0;
      foreach (io_ports[i]) rt(C, 4'h8, {18'h0, io_ports[i]}, A);
      rt(C, 4'h8, 34'h0_0001_0002, A);
      sad_host_model_i.send(C, 4'h8, 34'h0_0001_0003);
      @(posedge clk);
      #1 cmp("io_refused", route.valid, 1'b0);
      rt(C, 4'h0, 34'h0_000C_0000, A);
      rt(C, 4'h0, 34'h0_000F_0000, A);
      @(posedge clk) attr_wr <= 1;
      @(posedge clk) attr_wr <= 0;
      @(posedge clk) cmp("attr", shadow_attribute_region, attr_wdata);
      rt(C, 4'h0, 34'h0_000C_0000, MEM);
      rt(C, 4'h4, 34'h0_000C_3FFF, A);
      rt(C, 4'h0, 34'h0_000C_4000, A);
      rt(C, 4'h4, 34'h0_000C_7FFF, MEM);
      rt(C, 4'h4, 34'h0_000E_0000, MEM);
      rt(C, 4'h0, 34'h0_000E_4000, A);
      rt(C, 4'h0, 34'h0_000F_FFFF, MEM);
      rt(C, 4'h4, 34'h0_000F_0000, A);
      rt(H, 4'h4, 34'h0_000D_0000, MEM);
      rt(H, 4'h0, 34'h0_000E_0000, MEM);
      rt(C, 4'h0, 34'h0_00F0_0000, MEM);
      @(posedge clk) isa_hole_enable <= 1;
      rt(C, 4'h0, 34'h0_00F0_0000, A);
      rt(C, 4'h4, 34'h0_00FF_FFFF, A);
      rt(C, 4'h0, 34'h0_0100_0000, MEM);
      for (int i = 0; i < 4; i++)
         rt(C, 4'h0, 34'h0_FEC7_F000 + 34'(i << 12),
            sad_pkg::sad_dest_t'(1 + i));
      rt(H, 4'h0, 34'h0_FEC8_0000, A);
      rt(H, 4'h5, 34'h0_FEE0_0000, SYS, 2'h3);
      rt(sad_pkg::SAD_SRC_HUB_D, 4'h5, 34'h0_FEEF_FFFC, SYS, 2'h3);
      rt(H, 4'h4, 34'h0_FEE0_0000, A);
      rt(C, 4'h4, 34'h0_FEE0_0100, SYS, 2'h2);
      idr(2'h3, 8'h00, 16'h0000);
      foreach (ids[i]) idr(2'(i), 8'h02, ids[i]);
      repeat (3) @(posedge clk);
      cmp("ident_hold", ident_rdata, ids[3]);
      // Reset in mid-run clears route, attributes and read value
      @(posedge clk) rst_b <= 0;
      @(posedge clk) rst_b <= 1;
      #1 cmp("ident_reset", ident_rdata, 16'h0000);
      cmp("route_reset", route.valid, 1'b0);
      cmp("attr_reset2", shadow_attribute_region, 26'h0);
      rt(C, 4'h0, 34'h0_000F_0000, A);
      summarize();
   end
   // Whole sequence needs about 150 cycles
   initial begin
      repeat (2000) @(posedge clk);
      miscompares++;
      summarize();
   end
endmodule
`default_nettype wire
